/* File: emulator_probe.sv */
// emulator probe model: clocks the test port, reads serial data back
// assumes: test clock stands still low between scans
`default_nettype none
module emulator_probe (
  // test access port
  output var  logic tck,
  output var  logic tms,
  output var  logic tdi,
  input  wire logic tdo
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end
  // one 64 ns test clock, lines set while low, data read after the fall
  task automatic tick(input logic m, input logic d, output logic s);
    tms = m;
    tdi = d;
    #32 tck = 1'b1;
    #32 tck = 1'b0;
    s = tdo;
  endtask
  task automatic reset_tap();
    logic s;
    repeat (5) tick(1'b1, 1'b0, s);
    tick(1'b0, 1'b0, s);
  endtask
  // lsb-first scan from run-test-idle back to it, one idle clock after
  task automatic shift(input logic ir, input int n, input logic [39:0] d,
                       output logic [39:0] q);
    logic s;
    q = '0;
    tick(1'b1, 1'b0, s);
    if (ir) tick(1'b1, 1'b0, s);
    tick(1'b0, 1'b0, s);
    tick(1'b0, 1'b0, s);
    for (int i = 0; i < n; i++) begin
      tick(i == n - 1, d[i], s);
      q[i] = s;
    end
    tick(1'b1, 1'b0, s);
    tick(1'b0, 1'b0, s);
    tick(1'b0, 1'b0, s);
  endtask
endmodule
`default_nettype wire

/* File: jtag_emulation_control.sv */
// test access port with emulation halt/resume, status and control scans
// assumes: tck from the emulator probe, unrelated to ref_clk; core
// status inputs are on ref_clk; boundary pins are asynchronous
`include "jtag_emulation_control_params.svh"
`default_nettype none
// Functional notes
// - boundary chain for extest, intest, sample, idcode
// - runbist and usercode act as bypass
// - boundary cells master/slave on test clock
// - breakpoint raises interrupt, halts, awaits scans
// - scanned return instruction resumes user execution
// - breakpoint optionally halts dma activity
// - halt when mode-select rises, instruction scan
// - scanned instruction executes on idle return
// - control register reachable only through port
// - status captured from core in capture
// - shifted-in status data is ignored
// - status bits: emulator fetch, instructions done
// - status bits: was idle, hung; rest reserved
// - forty-bit control shift register via port
// - control bit 0 enables emulation
// - control bit 1 allows external breaks
// - control bit 2 allows internal breaks
// - control bit 4 resets core while set
// - control bit 5 enables status pin
// - control bit 6 blocks dma in debug
// - serial receive dropped with overrun flag while dma stopped
// - sixteen-state machine on rising test clock
// - five-bit instruction, bit 0 out first
module jtag_emulation_control (
  // core clock and reset
  input  wire logic                   ref_clk,
  input  wire logic                   rst_n,
  // test access port
  input  wire logic                   tck,
  input  wire logic                   tms,
  input  wire logic                   tdi,
  output var  logic                   tdo,
  output var  logic                   tdo_oe,
  // emulation status pin
  output var  logic                   emulation_status_pin,
  output var  logic                   emulation_status_pin_oe,
  // boundary pins
  input  wire logic [`EMC_BSR_N-1:0]  bsr_pin_in,
  output var  logic [`EMC_BSR_N-1:0]  bsr_pin_out,
  output var  logic                   bsr_drive,
  // breakpoint sources
  input  wire logic                   external_break_req,
  input  wire logic                   internal_break,
  // core status
  input  wire logic                   core_idle,
  input  wire logic                   core_insn_done,
  input  wire logic                   core_buffer_hung,
  // core control
  output var  logic                   core_halt,
  output var  logic                   emulator_irq,
  output var  logic                   emu_insn_valid,
  output var  logic [`EMC_EIR_W-1:0]  emu_insn,
  output var  logic                   emulator_soft_reset,
  output var  logic                   dma_stop,
  // serial port receive
  input  wire logic                   serial_rx_valid,
  input  wire logic                   serial_overrun_clr,
  output var  logic                   serial_overrun
);

  // boundary register selection
  function automatic logic is_bsr_insn(input logic [`EMC_IR_W-1:0] code);
    is_bsr_insn = (code == `EMC_IR_EXTEST) || (code == `EMC_IR_INTEST) ||
                  (code == `EMC_IR_SAMPLE) || (code == `EMC_IR_IDCODE);
  endfunction

  // standard state transitions
  function automatic jtag_emulation_control_pkg::tap_state_e tap_next(
    input jtag_emulation_control_pkg::tap_state_e cur,
    input logic                                   m
  );
    case (cur)
      jtag_emulation_control_pkg::ST_RESET:
        tap_next = m ? jtag_emulation_control_pkg::ST_RESET
                     : jtag_emulation_control_pkg::ST_IDLE;
      jtag_emulation_control_pkg::ST_IDLE:
        tap_next = m ? jtag_emulation_control_pkg::ST_SEL_DR
                     : jtag_emulation_control_pkg::ST_IDLE;
      jtag_emulation_control_pkg::ST_SEL_DR:
        tap_next = m ? jtag_emulation_control_pkg::ST_SEL_IR
                     : jtag_emulation_control_pkg::ST_CAP_DR;
      jtag_emulation_control_pkg::ST_CAP_DR:
        tap_next = m ? jtag_emulation_control_pkg::ST_EX1_DR
                     : jtag_emulation_control_pkg::ST_SH_DR;
      jtag_emulation_control_pkg::ST_SH_DR:
        tap_next = m ? jtag_emulation_control_pkg::ST_EX1_DR
                     : jtag_emulation_control_pkg::ST_SH_DR;
      jtag_emulation_control_pkg::ST_EX1_DR:
        tap_next = m ? jtag_emulation_control_pkg::ST_UPD_DR
                     : jtag_emulation_control_pkg::ST_PA_DR;
      jtag_emulation_control_pkg::ST_PA_DR:
        tap_next = m ? jtag_emulation_control_pkg::ST_EX2_DR
                     : jtag_emulation_control_pkg::ST_PA_DR;
      jtag_emulation_control_pkg::ST_EX2_DR:
        tap_next = m ? jtag_emulation_control_pkg::ST_UPD_DR
                     : jtag_emulation_control_pkg::ST_SH_DR;
      jtag_emulation_control_pkg::ST_UPD_DR:
        tap_next = m ? jtag_emulation_control_pkg::ST_SEL_DR
                     : jtag_emulation_control_pkg::ST_IDLE;
      jtag_emulation_control_pkg::ST_SEL_IR:
        tap_next = m ? jtag_emulation_control_pkg::ST_RESET
                     : jtag_emulation_control_pkg::ST_CAP_IR;
      jtag_emulation_control_pkg::ST_CAP_IR:
        tap_next = m ? jtag_emulation_control_pkg::ST_EX1_IR
                     : jtag_emulation_control_pkg::ST_SH_IR;
      jtag_emulation_control_pkg::ST_SH_IR:
        tap_next = m ? jtag_emulation_control_pkg::ST_EX1_IR
                     : jtag_emulation_control_pkg::ST_SH_IR;
      jtag_emulation_control_pkg::ST_EX1_IR:
        tap_next = m ? jtag_emulation_control_pkg::ST_UPD_IR
                     : jtag_emulation_control_pkg::ST_PA_IR;
      jtag_emulation_control_pkg::ST_PA_IR:
        tap_next = m ? jtag_emulation_control_pkg::ST_EX2_IR
                     : jtag_emulation_control_pkg::ST_PA_IR;
      jtag_emulation_control_pkg::ST_EX2_IR:
        tap_next = m ? jtag_emulation_control_pkg::ST_UPD_IR
                     : jtag_emulation_control_pkg::ST_SH_IR;
      jtag_emulation_control_pkg::ST_UPD_IR:
        tap_next = m ? jtag_emulation_control_pkg::ST_SEL_DR
                     : jtag_emulation_control_pkg::ST_IDLE;
      default:
        tap_next = jtag_emulation_control_pkg::ST_RESET;
    endcase
  endfunction

  jtag_emulation_control_pkg::tap_s  tap_r;
  jtag_emulation_control_pkg::tap_s  tap_nxt;
  jtag_emulation_control_pkg::core_s core_r;
  jtag_emulation_control_pkg::core_s core_nxt;
  logic [3:0]                        core_stat;

  // core-side status bits handed to the port
  assign core_stat = {core_r.hung, core_r.was_idle, core_r.done, core_r.emu_space};

  // test clock domain
  always_comb begin
    tap_nxt = tap_r;
    tap_nxt.st = tap_next(tap_r.st, tms);
    tap_nxt.pin_s1 = bsr_pin_in;
    tap_nxt.pin_s2 = tap_r.pin_s1;
    tap_nxt.stat_s1 = core_stat;
    tap_nxt.stat_s2 = tap_r.stat_s1;
    tap_nxt.tdo_oe = 1'b0;
    case (tap_r.st)
      jtag_emulation_control_pkg::ST_RESET: begin
        tap_nxt.ir = `EMC_IR_BYPASS;
      end
      jtag_emulation_control_pkg::ST_IDLE: begin
        if (tms && tap_r.ir == `EMC_IR_EIR && tap_r.ctl[`EMC_BIT_ENA]) begin
          tap_nxt.halt_tgl = ~tap_r.halt_tgl;
        end
        if (tap_r.exec_pend) begin
          tap_nxt.exec_tgl = ~tap_r.exec_tgl;
          tap_nxt.exec_pend = 1'b0;
        end
      end
      jtag_emulation_control_pkg::ST_CAP_IR: begin
        tap_nxt.ir_sh = `EMC_IR_CAPTURE;
      end
      jtag_emulation_control_pkg::ST_SH_IR: begin
        tap_nxt.ir_sh = {tdi, tap_r.ir_sh[`EMC_IR_W-1:1]};
        tap_nxt.tdo_oe = 1'b1;
      end
      jtag_emulation_control_pkg::ST_UPD_IR: begin
        tap_nxt.ir = tap_r.ir_sh;
      end
      jtag_emulation_control_pkg::ST_CAP_DR: begin
        tap_nxt.bsr_sh = tap_r.pin_s2;
        tap_nxt.stat_sh = {4'h0, tap_r.stat_s2};
        tap_nxt.ctl_sh = tap_r.ctl;
        tap_nxt.eir_sh = `EMC_INSN_NOP;
        tap_nxt.byp = 1'b0;
      end
      jtag_emulation_control_pkg::ST_SH_DR: begin
        tap_nxt.tdo_oe = 1'b1;
        if (is_bsr_insn(tap_r.ir)) begin
          tap_nxt.bsr_sh = {tdi, tap_r.bsr_sh[`EMC_BSR_N-1:1]};
        end else if (tap_r.ir == `EMC_IR_CTL) begin
          tap_nxt.ctl_sh = {tdi, tap_r.ctl_sh[`EMC_CTL_W-1:1]};
        end else if (tap_r.ir == `EMC_IR_STAT) begin
          tap_nxt.stat_sh = {1'b0, tap_r.stat_sh[`EMC_STAT_W-1:1]};
        end else if (tap_r.ir == `EMC_IR_EIR) begin
          tap_nxt.eir_sh = {tdi, tap_r.eir_sh[`EMC_EIR_W-1:1]};
        end else begin
          tap_nxt.byp = tdi;
        end
      end
      jtag_emulation_control_pkg::ST_UPD_DR: begin
        if (is_bsr_insn(tap_r.ir)) begin
          tap_nxt.bsr_upd = tap_r.bsr_sh;
        end else if (tap_r.ir == `EMC_IR_CTL) begin
          tap_nxt.ctl = tap_r.ctl_sh;
          tap_nxt.ctl_tgl = ~tap_r.ctl_tgl;
        end else if (tap_r.ir == `EMC_IR_EIR) begin
          tap_nxt.eir = tap_r.eir_sh;
          tap_nxt.exec_pend = 1'b1;
        end
      end
      default: begin
      end
    endcase
    // shift output from current chain head
    if (tap_r.st == jtag_emulation_control_pkg::ST_SH_IR) begin
      tap_nxt.tdo = tap_r.ir_sh[0];
    end else if (is_bsr_insn(tap_r.ir)) begin
      tap_nxt.tdo = tap_r.bsr_sh[0];
    end else if (tap_r.ir == `EMC_IR_CTL) begin
      tap_nxt.tdo = tap_r.ctl_sh[0];
    end else if (tap_r.ir == `EMC_IR_STAT) begin
      tap_nxt.tdo = tap_r.stat_sh[0];
    end else if (tap_r.ir == `EMC_IR_EIR) begin
      tap_nxt.tdo = tap_r.eir_sh[0];
    end else begin
      tap_nxt.tdo = tap_r.byp;
    end
    tap_nxt.bsr_drv = (tap_r.ir == `EMC_IR_EXTEST);
  end

  always_ff @(posedge tck or negedge rst_n) begin
    if (!rst_n) begin
      tap_r <= '0;
      tap_r.st <= jtag_emulation_control_pkg::ST_RESET;
      tap_r.ir <= `EMC_IR_BYPASS;
      tap_r.ctl <= `EMC_CTL_RESET;
    end else begin
      tap_r <= tap_nxt;
    end
  end

  // core clock domain
  always_comb begin
    core_nxt = core_r;
    // control word taken only once its update toggle has settled
    core_nxt.ctl_t = {core_r.ctl_t[1:0], tap_r.ctl_tgl};
    if (core_r.ctl_t[2] ^ core_r.ctl_t[1]) begin
      core_nxt.ctl_s1 = tap_r.ctl[`EMC_CTL_SYNC_W-1:0];
    end
    core_nxt.ctl_s2 = core_r.ctl_s1;
    core_nxt.halt_s = {core_r.halt_s[1:0], tap_r.halt_tgl};
    core_nxt.exec_s = {core_r.exec_s[1:0], tap_r.exec_tgl};
    core_nxt.ext_s1 = external_break_req;
    core_nxt.ext_s2 = core_r.ext_s1;
    core_nxt.irq = 1'b0;
    core_nxt.insn_valid = 1'b0;
    core_nxt.hung = core_buffer_hung;
    if (core_r.ctl_s2[`EMC_BIT_ENA] && !core_r.emu_space &&
        ((core_r.ctl_s2[`EMC_BIT_EXT] &&
          ((core_r.halt_s[2] ^ core_r.halt_s[1]) || core_r.ext_s2)) ||
         (core_r.ctl_s2[`EMC_BIT_HALT_ON_INTERNAL_BREAK] && internal_break))) begin
      core_nxt.emu_space = 1'b1;
      core_nxt.irq = 1'b1;
      core_nxt.was_idle = core_idle;
    end
    if (core_r.emu_space && (core_r.exec_s[2] ^ core_r.exec_s[1])) begin
      core_nxt.insn_valid = 1'b1;
      core_nxt.insn = tap_r.eir;
      core_nxt.done = 1'b0;
      if (tap_r.eir == `EMC_INSN_RTI) begin
        core_nxt.emu_space = 1'b0;
      end
    end
    if (core_insn_done) begin
      core_nxt.done = 1'b1;
    end
    core_nxt.soft_rst = core_r.ctl_s2[`EMC_BIT_SOFTRST];
    core_nxt.dma_stop = core_r.ctl_s2[`EMC_BIT_HALT_DMA_IN_DEBUG] && core_nxt.emu_space;
    if (serial_overrun_clr) begin
      core_nxt.overrun = 1'b0;
    end
    if (core_r.dma_stop && serial_rx_valid) begin
      core_nxt.overrun = 1'b1;
    end
    core_nxt.pin_oe = core_r.ctl_s2[`EMC_BIT_PINEN];
    core_nxt.pin_o = core_nxt.emu_space;
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      core_r <= '0;
    end else begin
      core_r <= core_nxt;
    end
  end

  // outputs straight from flops
  assign tdo = tap_r.tdo;
  assign tdo_oe = tap_r.tdo_oe;
  assign bsr_pin_out = tap_r.bsr_upd;
  assign bsr_drive = tap_r.bsr_drv;
  assign emulation_status_pin = core_r.pin_o;
  assign emulation_status_pin_oe = core_r.pin_oe;
  assign core_halt = core_r.emu_space;
  assign emulator_irq = core_r.irq;
  assign emu_insn_valid = core_r.insn_valid;
  assign emu_insn = core_r.insn;
  assign emulator_soft_reset = core_r.soft_rst;
  assign dma_stop = core_r.dma_stop;
  assign serial_overrun = core_r.overrun;

endmodule
`default_nettype wire

/* File: jtag_emulation_control_monitor.sv */
// assertions on the core-side ports of the test-port emulation block
// assumes: bound to jtag_emulation_control; params header on include path
`include "jtag_emulation_control_params.svh"
`default_nettype none
module jtag_emulation_control_monitor (
  // clock and reset
  input wire logic                  ref_clk,
  input wire logic                  rst_n,
  // observed ports
  input wire logic                  core_halt,
  input wire logic                  emulator_irq,
  input wire logic                  emu_insn_valid,
  input wire logic [`EMC_EIR_W-1:0] emu_insn,
  input wire logic                  emulation_status_pin,
  input wire logic                  emulation_status_pin_oe,
  input wire logic                  dma_stop,
  input wire logic                  serial_rx_valid,
  input wire logic                  serial_overrun_clr,
  input wire logic                  serial_overrun
);
  a_irq_on_entry: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(core_halt) |-> emulator_irq) else $error("no interrupt at halt");
  a_irq_pulse: assert property (@(posedge ref_clk) disable iff (!rst_n)
    emulator_irq |=> !emulator_irq && core_halt) else $error("interrupt not a pulse");
  a_pin_in_space: assert property (@(posedge ref_clk) disable iff (!rst_n)
    core_halt && emulation_status_pin_oe |-> ##[0:2] emulation_status_pin)
    else $error("status pin low in debug");
  a_pin_only_space: assert property (@(posedge ref_clk) disable iff (!rst_n)
    emulation_status_pin |-> core_halt || $past(core_halt)) else $error("status pin stray");
  a_dma_in_space: assert property (@(posedge ref_clk) disable iff (!rst_n)
    dma_stop |-> core_halt || $past(core_halt)) else $error("dma stopped while running");
  a_resume_on_return: assert property (@(posedge ref_clk) disable iff (!rst_n)
    emu_insn_valid && emu_insn == `EMC_INSN_RTI && $past(core_halt) |-> !core_halt)
    else $error("no resume on return");
  a_insn_pulse: assert property (@(posedge ref_clk) disable iff (!rst_n)
    emu_insn_valid |=> !emu_insn_valid) else $error("insn valid too long");
  a_insn_halted: assert property (@(posedge ref_clk) disable iff (!rst_n)
    emu_insn_valid |-> $past(core_halt)) else $error("insn while running");
  a_overrun_set: assert property (@(posedge ref_clk) disable iff (!rst_n)
    serial_rx_valid && dma_stop |-> ##[1:2] serial_overrun) else $error("overrun not set");
  a_overrun_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
    serial_overrun && !serial_overrun_clr |=> serial_overrun) else $error("overrun lost");
  c_halt: cover property (@(posedge ref_clk) disable iff (!rst_n) $rose(core_halt));
  c_return: cover property (@(posedge ref_clk) disable iff (!rst_n) $fell(core_halt));
  c_overrun: cover property (@(posedge ref_clk) disable iff (!rst_n) $rose(serial_overrun));
endmodule
bind jtag_emulation_control jtag_emulation_control_monitor mon_u (
  .ref_clk(ref_clk), .rst_n(rst_n), .core_halt(core_halt), .emulator_irq(emulator_irq),
  .emu_insn_valid(emu_insn_valid), .emu_insn(emu_insn), .dma_stop(dma_stop),
  .emulation_status_pin(emulation_status_pin),
  .emulation_status_pin_oe(emulation_status_pin_oe), .serial_rx_valid(serial_rx_valid),
  .serial_overrun_clr(serial_overrun_clr), .serial_overrun(serial_overrun));
`default_nettype wire

/* File: jtag_emulation_control_params.svh */
// constants of the test-port emulation block
// assumes: included by package, top module, monitor and bench
`ifndef JTAG_EMULATION_CONTROL_PARAMS_SVH
`define JTAG_EMULATION_CONTROL_PARAMS_SVH
`define EMC_IR_W 5
`define EMC_CTL_W 40
`define EMC_STAT_W 8
`define EMC_EIR_W 32
`define EMC_BSR_N 8
`define EMC_IR_EXTEST 5'h00
`define EMC_IR_SAMPLE 5'h01
`define EMC_IR_INTEST 5'h02
`define EMC_IR_IDCODE 5'h03
`define EMC_IR_RUNBIST 5'h04
`define EMC_IR_USERCODE 5'h05
`define EMC_IR_CTL 5'h10
`define EMC_IR_STAT 5'h11
`define EMC_IR_EIR 5'h12
`define EMC_IR_BYPASS 5'h1F
`define EMC_IR_CAPTURE 5'h01
`define EMC_CTL_RESET 40'h00_0000_0000
`define EMC_BIT_ENA 0
`define EMC_BIT_EXT 1
`define EMC_BIT_HALT_ON_INTERNAL_BREAK 2
`define EMC_BIT_SOFTRST 4
`define EMC_BIT_PINEN 5
`define EMC_BIT_HALT_DMA_IN_DEBUG 6
`define EMC_CTL_SYNC_W 7
`define EMC_INSN_RTI 32'h0000_00B0
`define EMC_INSN_NOP 32'h0000_0000
`endif

/* File: jtag_emulation_control_pkg.sv */
// types of the test-port emulation block
// assumes: params header on the include path
`include "jtag_emulation_control_params.svh"
`default_nettype none
package jtag_emulation_control_pkg;
  typedef enum logic [15:0] {
    ST_RESET = 16'h0001, ST_IDLE = 16'h0002, ST_SEL_DR = 16'h0004, ST_CAP_DR = 16'h0008,
    ST_SH_DR = 16'h0010, ST_EX1_DR = 16'h0020, ST_PA_DR = 16'h0040, ST_EX2_DR = 16'h0080,
    ST_UPD_DR = 16'h0100, ST_SEL_IR = 16'h0200, ST_CAP_IR = 16'h0400, ST_SH_IR = 16'h0800,
    ST_EX1_IR = 16'h1000, ST_PA_IR = 16'h2000, ST_EX2_IR = 16'h4000, ST_UPD_IR = 16'h8000
  } tap_state_e;
  typedef struct packed {
    tap_state_e              st;
    logic [`EMC_IR_W-1:0]    ir_sh;
    logic [`EMC_IR_W-1:0]    ir;
    logic [`EMC_CTL_W-1:0]   ctl_sh;
    logic [`EMC_CTL_W-1:0]   ctl;
    logic [`EMC_STAT_W-1:0]  stat_sh;
    logic [`EMC_EIR_W-1:0]   eir_sh;
    logic [`EMC_EIR_W-1:0]   eir;
    logic                    byp;
    logic [`EMC_BSR_N-1:0]   bsr_sh;
    logic [`EMC_BSR_N-1:0]   bsr_upd;
    logic                    bsr_drv;
    logic [`EMC_BSR_N-1:0]   pin_s1;
    logic [`EMC_BSR_N-1:0]   pin_s2;
    logic [3:0]              stat_s1;
    logic [3:0]              stat_s2;
    logic                    halt_tgl;
    logic                    ctl_tgl;
    logic                    exec_pend;
    logic                    exec_tgl;
    logic                    tdo;
    logic                    tdo_oe;
  } tap_s;
  typedef struct packed {
    logic [`EMC_CTL_SYNC_W-1:0] ctl_s1;
    logic [`EMC_CTL_SYNC_W-1:0] ctl_s2;
    logic [2:0]              ctl_t;
    logic [2:0]              halt_s;
    logic [2:0]              exec_s;
    logic                    ext_s1;
    logic                    ext_s2;
    logic                    emu_space;
    logic                    done;
    logic                    was_idle;
    logic                    hung;
    logic                    irq;
    logic                    insn_valid;
    logic [`EMC_EIR_W-1:0]   insn;
    logic                    soft_rst;
    logic                    dma_stop;
    logic                    overrun;
    logic                    pin_o;
    logic                    pin_oe;
  } core_s;
endpackage
`default_nettype wire

/* File: jtag_emulation_control_tb.sv */
// self-checking bench: probe model scans the port, bench drives the core side
// assumes: package, design, monitor and probe model compiled first
`include "jtag_emulation_control_params.svh"
`default_nettype none
module jtag_emulation_control_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic                  ref_clk, rst_n, tck, tms, tdi, tdo, tdo_oe, bsr_drive;
  logic                  emulation_status_pin, emulation_status_pin_oe, core_idle;
  logic                  external_break_req, internal_break, core_insn_done, dma_stop;
  logic                  core_buffer_hung, core_halt, emulator_irq, emu_insn_valid;
  logic                  emulator_soft_reset, serial_rx_valid, serial_overrun_clr;
  logic                  serial_overrun, insn_seen, halt_seen;
  logic [`EMC_BSR_N-1:0] bsr_pin_in, bsr_pin_out;
  logic [`EMC_EIR_W-1:0] emu_insn, insn_got;
  logic [`EMC_IR_W-1:0]  codes [6];
  logic [39:0]           q;
  time                   halt_t;
  int                    mismatches, check_count;
  jtag_emulation_control dut_u (
    .ref_clk(ref_clk), .rst_n(rst_n), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
    .tdo_oe(tdo_oe), .emulation_status_pin(emulation_status_pin),
    .emulation_status_pin_oe(emulation_status_pin_oe), .bsr_pin_in(bsr_pin_in),
    .bsr_pin_out(bsr_pin_out), .bsr_drive(bsr_drive), .external_break_req(external_break_req),
    .internal_break(internal_break), .core_idle(core_idle), .core_insn_done(core_insn_done),
    .core_buffer_hung(core_buffer_hung), .core_halt(core_halt), .emulator_irq(emulator_irq),
    .emu_insn_valid(emu_insn_valid), .emu_insn(emu_insn),
    .emulator_soft_reset(emulator_soft_reset), .dma_stop(dma_stop),
    .serial_rx_valid(serial_rx_valid), .serial_overrun_clr(serial_overrun_clr),
    .serial_overrun(serial_overrun));
  emulator_probe probe_u (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  // catches one-cycle pulses and the moment of halt
  always @(posedge ref_clk) begin
    if (emu_insn_valid === 1'b1) begin
      insn_seen <= 1'b1;
      insn_got  <= emu_insn;
    end
    if (core_halt === 1'b1 && !halt_seen) begin
      halt_seen <= 1'b1;
      halt_t    <= $time;
    end
  end
  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // ends off both clocks' edges so test-clock edges never meet core edges
  task automatic rwait(input int n);
    repeat (n) @(posedge ref_clk);
    #1.2;
  endtask
  task automatic wait_hi(input logic k);
    for (int i = 0; i < 400; i++) begin
      rwait(1);
      if ((k ? emulator_soft_reset : emulation_status_pin_oe) === 1'b1) return;
    end
    mismatches++;
    $display("unexpected at %0t: wait ran out", $time);
    final_report();
  endtask
  task automatic pulse(input int k);
    @(posedge ref_clk);
    case (k)
      0: internal_break <= 1'b1;
      1: serial_rx_valid <= 1'b1;
      default: core_insn_done <= 1'b1;
    endcase
    @(posedge ref_clk);
    internal_break <= 1'b0;
    serial_rx_valid <= 1'b0;
    core_insn_done <= 1'b0;
    rwait(20);
  endtask
  task automatic ir(input logic [`EMC_IR_W-1:0] c);
    probe_u.shift(1'b1, `EMC_IR_W, {35'h0, c}, q);
    chk(q[4:0], `EMC_IR_CAPTURE);
    chk(tdo_oe, 1'b0);
  endtask
  task automatic dr(input int n, input logic [39:0] d);
    probe_u.shift(1'b0, n, d, q);
  endtask
  initial begin
    rst_n = 1'b0;
    bsr_pin_in = 8'h5A;
    external_break_req = 1'b0;
    internal_break = 1'b0;
    core_idle = 1'b0;
    core_insn_done = 1'b0;
    core_buffer_hung = 1'b1;
    serial_rx_valid = 1'b0;
    serial_overrun_clr = 1'b0;
    insn_seen = 1'b0;
    halt_seen = 1'b0;
    mismatches = 0;
    check_count = 0;
    codes = '{`EMC_IR_EXTEST, `EMC_IR_SAMPLE, `EMC_IR_INTEST, `EMC_IR_IDCODE,
              `EMC_IR_RUNBIST, `EMC_IR_USERCODE};
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    rwait(2);
    probe_u.reset_tap();
    ir(`EMC_IR_CTL);
    dr(40, 40'hA5_0000_0000);
    chk(q, `EMC_CTL_RESET);
    dr(40, 40'h00_0000_0010);
    chk(q, 40'hA5_0000_0000);
    wait_hi(1'b1);
    dr(40, 40'h00_0000_0063);
    wait_hi(1'b0);
    chk(emulator_soft_reset, 1'b0);
    chk(core_halt, 1'b0);
    pulse(0);
    chk(core_halt, 1'b0);
    pulse(1);
    chk(serial_overrun, 1'b0);
    ir(`EMC_IR_STAT);
    dr(8, 40'hFF);
    chk(q[7:0], 8'h08);
    dr(8, 40'hFF);
    chk(q[7:0], 8'h08);
    for (int i = 0; i < 6; i++) begin
      ir(codes[i]);
      chk(bsr_drive, i == 0);
      dr(8, 40'hC3);
      chk(q[7:0], i < 4 ? 8'h5A : 8'h86);
      if (i == 0) chk(bsr_pin_out, 8'hC3);
    end
    @(posedge ref_clk);
    core_buffer_hung <= 1'b0;
    core_idle <= 1'b1;
    rwait(4);
    ir(`EMC_IR_EIR);
    dr(`EMC_EIR_W, `EMC_INSN_NOP);
    chk(halt_seen && halt_t + 1024 < $time, 1'b1);
    rwait(20);
    chk(insn_got, `EMC_INSN_NOP);
    chk(emulation_status_pin, 1'b1);
    chk(dma_stop, 1'b1);
    pulse(1);
    chk(serial_overrun, 1'b1);
    pulse(2);
    ir(`EMC_IR_STAT);
    dr(8, 40'h00);
    chk(q[7:0], 8'h07);
    insn_seen = 1'b0;
    ir(`EMC_IR_EIR);
    dr(`EMC_EIR_W, `EMC_INSN_RTI);
    rwait(20);
    chk(insn_seen, 1'b1);
    chk(core_halt, 1'b0);
    chk(dma_stop, 1'b0);
    @(posedge ref_clk);
    external_break_req <= 1'b1;
    rwait(10);
    chk(core_halt, 1'b1);
    @(posedge ref_clk);
    external_break_req <= 1'b0;
    final_report();
  end
endmodule
`default_nettype wire
